// File: hdl/pec_counter.sv
// One event counter with a software load port.
// Assumes load and inc are single-cycle qualifiers on aclk.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module pec_counter #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic inc,
  // Count
  output logic [W-1:0] count
);
  logic [W-1:0] count_reg;

  // Top bit must exist for the overflow flag
  if (W < 2) begin : g_bad_w
    $error("pec_counter: W must be at least 2");
  end

  // Load beats increment; no saturation, so counting runs past bit W-1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= W'(`PEC_CNT_RST);
    end else if (load) begin
      count_reg <= load_value;
    end else if (inc) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign count = count_reg;
endmodule : pec_counter

// File: hdl/pec_event_sel.sv
// Event selection for both counters: maps each selector code to a strobe; first code 0 is constant 1, second code 15 constant 0.
// Assumes strobes come from logic on aclk; output is purely combinational.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module pec_event_sel (
  // Pipeline strobes
  input wire pec_pkg::pec_evt_t evt,
  // Selector codes
  input wire logic [3:0] first_sel_code,
  input wire logic [3:0] second_sel_code,
  // Selected event per counter
  output logic [1:0] hit
);
  import pec_pkg::*;
  logic hit0;
  logic hit1;

  // Exception strobe carrying a given code
  function automatic logic exc_is(input pec_evt_t e, input logic [5:0] code);
    return e.exc_valid && (e.exc_code == code);
  endfunction : exc_is

  // First counter events
  always_comb begin
    unique case (first_sel_code)
      4'h0: hit0 = 1'b1;
      4'h1: hit0 = evt.branch;
      4'h2: hit0 = evt.jr;
      4'h3: hit0 = evt.jr31;
      4'h4: hit0 = evt.icache_miss;
      4'h5: hit0 = evt.alu1_iss;
      4'h6: hit0 = evt.mem_iss;
      4'h7: hit0 = evt.falu1_iss;
      4'h8: hit0 = evt.cp0_fwd;
      4'h9: hit0 = evt.mem_rd;
      4'hA: hit0 = evt.fxq_full;
      4'hB: hit0 = evt.roq_full;
      4'hC: hit0 = evt.cp0q_full;
      4'hD: hit0 = exc_is(evt, `PEC_EXC_REFILL_A) || exc_is(evt, `PEC_EXC_REFILL_B);
      4'hE: hit0 = exc_is(evt, `PEC_EXC_INTR);
      4'hF: hit0 = exc_is(evt, `PEC_EXC_INTERNAL);
    endcase
  end

  // Second counter events; code 15 never counts
  always_comb begin
    unique case (second_sel_code)
      4'h0: hit1 = evt.commit;
      4'h1: hit1 = evt.br_miss;
      4'h2: hit1 = evt.jr_miss;
      4'h3: hit1 = evt.jr31_miss;
      4'h4: hit1 = evt.dcache_miss;
      4'h5: hit1 = evt.alu2_iss;
      4'h6: hit1 = evt.falu2_iss;
      4'h7: hit1 = evt.uncached;
      4'h8: hit1 = evt.store;
      4'h9: hit1 = evt.mem_wr;
      4'hA: hit1 = evt.ftq_full;
      4'hB: hit1 = evt.brq_full;
      4'hC: hit1 = evt.exc_valid && evt.itlb_probe;
      4'hD: hit1 = evt.exc_valid;
      4'hE: hit1 = evt.ld_spec_miss;
      4'hF: hit1 = 1'b0;
    endcase
  end

  assign hit = {hit1, hit0};
endmodule : pec_event_sel

// File: hdl/pec_top.sv
// Performance event counters: AXI4-Lite register slave, qualifiers, overflow.
// Assumes pipeline strobes and mode bits are synchronous to aclk.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module pec_top #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pipeline side
  input wire pec_pkg::pec_evt_t pipe_evt,
  input wire pec_pkg::pec_mode_t cpu_mode,
  // Interrupt
  output logic overflow_irq_line
);
  import pec_pkg::*;

  // Decode needs room for four words below bit 4
  if (AW < 5) begin : g_bad_aw
    $error("pec_top: AW must be at least 5");
  end

  logic [`PEC_CTRL_W-1:0] ctrl_reg;
  logic [`PEC_CTRL_W-1:0] ctrl_next;
  logic [31:0] stage_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic wr_take;
  logic rd_take;
  logic [AW-1:0] wr_word;
  logic [AW-1:0] rd_word;
  logic [3:0] first_sel_code;
  logic [3:0] second_sel_code;
  logic ovf_irq_en;
  logic count_en;
  logic [1:0] hit;
  logic [1:0] inc;
  logic [1:0] load;
  logic [31:0] load_val [2];
  logic [31:0] cnt [2];
  logic [31:0] first_count_value;
  logic [31:0] second_count_value;
  logic cnt_hi_wr;

  // Only the four low words are mapped
  function automatic logic is_mapped(input logic [AW-1:0] a);
    return a[AW-1:4] == '0;
  endfunction : is_mapped

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Word-aligned addresses; low two bits ignored
  assign wr_word = {s_axi_awaddr[AW-1:2], 2'b00};
  assign rd_word = {s_axi_araddr[AW-1:2], 2'b00};

  // Control fields, all in one register
  assign second_sel_code = ctrl_reg[`PEC_SEL1_HI:`PEC_SEL1_LO];
  assign first_sel_code = ctrl_reg[`PEC_SEL0_HI:`PEC_SEL0_LO];
  assign ovf_irq_en = ctrl_reg[`PEC_IE_BIT];
  assign first_count_value = cnt[0];
  assign second_count_value = cnt[1];

  // Write channel: address and data taken together, one write in flight
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read channel: one read in flight
  assign rd_take = s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PEC_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(s_axi_awaddr) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Only the 13 defined control bits are stored
  always_comb begin
    logic [31:0] m;
    m = merge({{(32-`PEC_CTRL_W){1'b0}}, ctrl_reg}, s_axi_wdata, s_axi_wstrb);
    ctrl_next = m[`PEC_CTRL_W-1:0];
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `PEC_CTRL_RST;
    end else if (wr_take && wr_word == `PEC_CTRL_LO_OFS) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Low half staged so both counters load in one cycle on the high write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_reg <= `PEC_CNT_RST;
    end else if (wr_take && wr_word == `PEC_CNT_LO_OFS) begin
      stage_reg <= merge(first_count_value, s_axi_wdata, s_axi_wstrb);
    end
  end

  assign cnt_hi_wr = wr_take && wr_word == `PEC_CNT_HI_OFS;
  assign load = {cnt_hi_wr, cnt_hi_wr};
  assign load_val[0] = stage_reg;
  assign load_val[1] = merge(second_count_value, s_axi_wdata, s_axi_wstrb);

  // Mode qualifiers; handler and error levels override privilege
  always_comb begin
    logic base_ok;
    base_ok = !cpu_mode.handler_level_flag && !cpu_mode.error_level_flag;
    count_en =
      (ctrl_reg[`PEC_QK_BIT] && base_ok &&
       cpu_mode.privilege_mode_field == `PEC_PRIV_KERN) ||
      (ctrl_reg[`PEC_QS_BIT] && base_ok &&
       cpu_mode.privilege_mode_field == `PEC_PRIV_SUPV) ||
      (ctrl_reg[`PEC_QU_BIT] && base_ok &&
       cpu_mode.privilege_mode_field == `PEC_PRIV_USER) ||
      (ctrl_reg[`PEC_QX_BIT] && cpu_mode.handler_level_flag &&
       !cpu_mode.error_level_flag);
  end

  // Event selection
  pec_event_sel u_sel (
    .evt(pipe_evt),
    .first_sel_code(first_sel_code),
    .second_sel_code(second_sel_code),
    .hit(hit)
  );

  assign inc = hit & {2{count_en}};

  // The two counters
  for (genvar g = 0; g < 2; g++) begin : g_cnt
    pec_counter #(.W(32)) u_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load[g]),
      .load_value(load_val[g]),
      .inc(inc[g]),
      .count(cnt[g])
    );
  end

  // Read data mux; reserved high control word reads zero
  always_comb begin
    unique case (rd_word)
      `PEC_CTRL_LO_OFS: rdata_next = {{(32-`PEC_CTRL_W){1'b0}}, ctrl_reg};
      `PEC_CTRL_HI_OFS: rdata_next = 32'h0000_0000;
      `PEC_CNT_LO_OFS: rdata_next = first_count_value;
      `PEC_CNT_HI_OFS: rdata_next = second_count_value;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `PEC_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(s_axi_araddr) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
      rdata_reg <= rdata_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Level request; one cycle behind the counts, so a rewrite drops it next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ovf_irq_en && (cnt[0][31] || cnt[1][31]);
    end
  end

  assign overflow_irq_line = irq_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // Response code follows the address that was taken, not the previous write
  sequence s_wr_resp;
    s_axi_bvalid && ((s_axi_bresp == `PEC_RESP_OKAY) == $past(is_mapped(s_axi_awaddr)));
  endsequence

  a_wr_resp_follows: assert property (s_wr_taken |=> s_wr_resp)
    else $error("write response not raised after write taken");

  a_irq_level: assert property (
    ovf_irq_en && cnt[0][31] && $stable(ovf_irq_en) && !load[0] ##1 ovf_irq_en
    |-> overflow_irq_line)
    else $error("overflow line low while enabled and bit 31 set");

  a_irq_drop: assert property (
    !ovf_irq_en |=> !overflow_irq_line)
    else $error("overflow line high with enable clear");

  a_ctrl_hi_zero: assert property (
    rd_take && rd_word == `PEC_CTRL_HI_OFS |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("reserved control word read non-zero");

  a_count_step: assert property (
    inc[0] && !load[0] |=> cnt[0] == $past(cnt[0]) + 32'h0000_0001)
    else $error("first counter missed an increment");

  a_count_hold: assert property (
    !inc[1] && !load[1] |=> cnt[1] == $past(cnt[1]))
    else $error("second counter moved without an event");

  a_past_top_bit: assert property (
    cnt[1][31] && inc[1] && !load[1] |=> cnt[1] == $past(cnt[1]) + 32'h0000_0001)
    else $error("counter stopped after top bit set");

  a_load_both: assert property (
    cnt_hi_wr && inc[0] |=> cnt[0] == $past(stage_reg) && cnt[1] == $past(load_val[1]))
    else $error("count write did not load both counters");

  a_kernel_qual: assert property (
    ctrl_reg[`PEC_QK_BIT] && !ctrl_reg[`PEC_QU_BIT] && !ctrl_reg[`PEC_QX_BIT] &&
    cpu_mode.privilege_mode_field == `PEC_PRIV_USER |-> !count_en)
    else $error("kernel qualifier counted in user mode");

  a_handler_qual: assert property (
    ctrl_reg[`PEC_QX_BIT] && cpu_mode.handler_level_flag && !cpu_mode.error_level_flag
    |-> count_en)
    else $error("handler qualifier failed to enable counting");

  a_cycle_code: assert property (
    first_sel_code == 4'h0 && count_en && !load[0] ##1 first_sel_code == 4'h0 &&
    count_en && !load[0] |=> cnt[0] == $past(cnt[0], 2) + 32'h0000_0002)
    else $error("cycle code did not count every cycle");
endmodule : pec_top

// File: pkg/pec_cfg.svh
// Constants of the performance event counter block: offsets, fields, resets.
// Assumes inclusion by bare name from any file of the block.
`ifndef PEC_CFG_SVH
`define PEC_CFG_SVH
// Word offsets on the register bus
`define PEC_CTRL_LO_OFS 12'h000
`define PEC_CTRL_HI_OFS 12'h004
`define PEC_CNT_LO_OFS 12'h008
`define PEC_CNT_HI_OFS 12'h00C
// Control field positions
`define PEC_SEL1_HI 12
`define PEC_SEL1_LO 9
`define PEC_SEL0_HI 8
`define PEC_SEL0_LO 5
`define PEC_IE_BIT 4
`define PEC_QU_BIT 3
`define PEC_QS_BIT 2
`define PEC_QK_BIT 1
`define PEC_QX_BIT 0
`define PEC_CTRL_W 13
// Reset values
`define PEC_CTRL_RST 13'h0000
`define PEC_CNT_RST 32'h0000_0000
// Privilege codes and exception codes
`define PEC_PRIV_KERN 2'h0
`define PEC_PRIV_SUPV 2'h1
`define PEC_PRIV_USER 2'h2
`define PEC_EXC_REFILL_A 6'h22
`define PEC_EXC_REFILL_B 6'h23
`define PEC_EXC_INTR 6'h00
`define PEC_EXC_INTERNAL 6'h3F
// Bus responses
`define PEC_RESP_OKAY 2'h0
`define PEC_RESP_SLVERR 2'h2
`endif

// File: pkg/pec_pkg.sv
// Types of the performance event counter block.
// Assumes the pipeline drives all strobes on aclk, one cycle per event.
package pec_pkg;
  // Pipeline event strobes, one bit per occurrence
  typedef struct packed {
    logic branch;
    logic jr;
    logic jr31;
    logic icache_miss;
    logic alu1_iss;
    logic mem_iss;
    logic falu1_iss;
    logic cp0_fwd;
    logic mem_rd;
    logic fxq_full;
    logic roq_full;
    logic cp0q_full;
    logic exc_valid;
    logic [5:0] exc_code;
    logic itlb_probe;
    logic commit;
    logic br_miss;
    logic jr_miss;
    logic jr31_miss;
    logic dcache_miss;
    logic alu2_iss;
    logic falu2_iss;
    logic uncached;
    logic store;
    logic mem_wr;
    logic ftq_full;
    logic brq_full;
    logic ld_spec_miss;
  } pec_evt_t;
  // Current processor mode bits
  typedef struct packed {
    logic [1:0] privilege_mode_field;
    logic handler_level_flag;
    logic error_level_flag;
  } pec_mode_t;
endpackage : pec_pkg

// File: verif/pec_pipe_model.sv
// Pipeline partner: random event strobes and processor mode bits on aclk.
// Assumes the bench seeds the random generator before the first edge.
`timescale 1ns/1ps
module pec_pipe_model (
  // Clock
  input wire logic aclk,
  // Strobes and mode towards the counters
  output pec_pkg::pec_evt_t evt,
  output pec_pkg::pec_mode_t mode
);
  import pec_pkg::*;
  logic [63:0] rnd;
  pec_evt_t nx;
  // Quiet until the first edge
  initial begin
    evt = '0;
    mode = '0;
  end
  // Fresh strobes each cycle; codes biased to the counted exception set
  always @(posedge aclk) begin
    rnd = {$urandom(), $urandom()};
    nx = pec_evt_t'(rnd[$bits(pec_evt_t)-1:0]);
    case (rnd[63:61])
      3'h0: nx.exc_code = 6'h22;
      3'h1: nx.exc_code = 6'h23;
      3'h2: nx.exc_code = 6'h00;
      3'h3: nx.exc_code = 6'h3F;
      default: ;
    endcase
    evt <= nx;
    // Error level rarer than handler level, so privileged counting dominates
    mode <= pec_mode_t'({rnd[60:59], rnd[58:57] == 2'h0, rnd[56:54] == 3'h0});
  end
endmodule : pec_pipe_model

// File: verif/tb.sv
// Bench for the event counters: bus master, reference model, checks.
// Assumes the pipeline partner model and a 125 MHz aclk.
`timescale 1ns/1ps
module tb;
  import pec_pkg::*;
  logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wrdy, arr, bv, rv, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdd, c0, c1, stage, exp_rd, tmp;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, exp_rr, exp_br;
  logic [12:0] ctrl;
  logic exp_irq, nirq, i0, i1;
  pec_evt_t evt;
  pec_mode_t mode;
  int failures = 0;
  int cmp_count = 0;

  pec_top #(.AW(12)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .pipe_evt(evt), .cpu_mode(mode), .overflow_irq_line(irq)
  );
  pec_pipe_model i_pipe (.aclk(aclk), .evt(evt), .mode(mode));

  // Clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] mrg(input logic [31:0] o, d, input logic [3:0] s);
    mrg = o;
    for (int b = 0; b < 4; b++) if (s[b]) mrg[8*b+:8] = d[8*b+:8];
  endfunction : mrg

  function automatic logic [31:0] regval(input logic [11:0] a);
    case (a[11:2])
      10'h000: return {19'h0_0000, ctrl};
      10'h002: return c0;
      10'h003: return c1;
      default: return 32'h0000_0000;
    endcase
  endfunction : regval

  function automatic logic [1:0] rsp(input logic [11:0] a);
    return (a < 12'h010) ? 2'h0 : 2'h2;
  endfunction : rsp

  function automatic logic qual(input logic [12:0] k, input pec_mode_t m);
    logic base;
    base = !m.handler_level_flag && !m.error_level_flag;
    return (k[1] && base && m.privilege_mode_field == 2'h0)
      || (k[2] && base && m.privilege_mode_field == 2'h1)
      || (k[3] && base && m.privilege_mode_field == 2'h2)
      || (k[0] && m.handler_level_flag && !m.error_level_flag);
  endfunction : qual

  function automatic logic hit0(input logic [3:0] c, input pec_evt_t e);
    logic [15:0] v;
    v = {e.exc_valid && e.exc_code == 6'h3F, e.exc_valid && e.exc_code == 6'h00,
      e.exc_valid && (e.exc_code == 6'h22 || e.exc_code == 6'h23),
      e.cp0q_full, e.roq_full, e.fxq_full, e.mem_rd, e.cp0_fwd,
      e.falu1_iss, e.mem_iss, e.alu1_iss, e.icache_miss,
      e.jr31, e.jr, e.branch, 1'b1};
    return v[c];
  endfunction : hit0

  function automatic logic hit1(input logic [3:0] c, input pec_evt_t e);
    logic [15:0] v;
    v = {1'b0, e.ld_spec_miss, e.exc_valid, e.exc_valid && e.itlb_probe,
      e.brq_full, e.ftq_full, e.mem_wr, e.store,
      e.uncached, e.falu2_iss, e.alu2_iss, e.dcache_miss,
      e.jr31_miss, e.jr_miss, e.br_miss, e.commit};
    return v[c];
  endfunction : hit1

  // Reference model: sees pre-edge values, applies loads over increments
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl = '0;
      c0 = '0;
      c1 = '0;
      stage = '0;
      exp_irq = 1'b0;
    end else begin
      if (arv && arr) begin
        exp_rd = regval(ara);
        exp_rr = rsp(ara);
      end
      nirq = ctrl[4] && (c0[31] || c1[31]);
      i0 = qual(ctrl, mode) && hit0(ctrl[8:5], evt);
      i1 = qual(ctrl, mode) && hit1(ctrl[12:9], evt);
      if (awv && awr) begin
        exp_br = rsp(awa);
        tmp = mrg({19'h0_0000, ctrl}, wd, ws);
        case (awa[11:2])
          10'h000: ctrl = tmp[12:0];
          10'h002: stage = mrg(c0, wd, ws);
          10'h003: begin
            c0 = stage;
            c1 = mrg(c1, wd, ws);
          end
          default: ;
        endcase
      end
      if (!(awv && awr && awa[11:2] == 10'h003)) begin
        c0 = c0 + 32'(i0);
        c1 = c1 + 32'(i1);
      end
      exp_irq = nirq;
    end
  end

  // Interrupt level watched every cycle, away from the edge
  always @(negedge aclk) if (aresetn) check({31'h0000_0000, irq}, {31'h0000_0000, exp_irq});

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    // Each channel held until its own ready, then released
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awr === 1'b1) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && wrdy === 1'b1) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    bready <= 1'b0;
    check({30'h0000_0000, bresp}, {30'h0000_0000, exp_br});
  endtask : bus_wr

  task automatic bus_rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    rready <= 1'b0;
    check(rdd, exp_rd);
    check({30'h0000_0000, rresp}, {30'h0000_0000, exp_rr});
  endtask : bus_rd

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Hang guard, well beyond the expected run
  initial begin
    repeat (8000) @(posedge aclk);
    failures++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(20227));
    {awv, wv, bready, arv, rready, aresetn} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    ws = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(12'h000);
    bus_rd(12'h00C);
    bus_rd(12'h010);
    bus_wr(12'h000, 32'hFFFF_FFFF, 4'hF);
    bus_rd(12'h000);
    bus_rd(12'h004);
    bus_wr(12'h014, $urandom(), 4'hF);
    // Every selector code on both counters, each qualifier in turn
    for (int i = 0; i < 16; i++) begin
      bus_wr(12'h000, {19'h0_0000, 4'(i), 4'(15 - i), 1'b0, 4'(1 << (i % 4))}, 4'hF);
      bus_wr(12'h008, $urandom(), 4'hF);
      bus_wr(12'h00C, $urandom(), 4'hF);
      repeat (20) @(posedge aclk);
      bus_rd(12'h008);
      bus_rd(12'h00C);
    end
    // Overflow, counting past it, then both ways of dropping the request
    bus_wr(12'h000, 32'h0000_001F, 4'hF);
    bus_wr(12'h008, 32'h7FFF_FFF0, 4'hF);
    bus_wr(12'h00C, 32'h7FFF_FFF8, 4'hF);
    repeat (40) @(posedge aclk);
    bus_rd(12'h008);
    bus_rd(12'h00C);
    bus_wr(12'h000, 32'h0000_000F, 4'hF);
    bus_wr(12'h000, 32'h0000_001F, 4'hF);
    bus_wr(12'h008, 32'h0000_0000, 4'hF);
    bus_wr(12'h00C, 32'h0000_0000, 4'hF);
    bus_wr(12'h000, $urandom(), 4'($urandom()));
    bus_rd(12'h000);
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(12'h000);
    results();
  end
endmodule : tb
